/* File: pws_pkg.sv */
`default_nettype none
package pws_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 8;
    localparam int unsigned DEBOUNCE_MS       = 50;
    // Least debounce time, rounded up to whole cycles
    localparam int unsigned DEBOUNCE_CYCLES_DEF =
        (DEBOUNCE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DEB_W             = 24;
    localparam int unsigned PD_DELAY_CYCLES   = 32;
    localparam int unsigned WAKE_DELAY_CYCLES = 512;
    localparam int unsigned POR_CYCLES        = 16;
    localparam int unsigned DLY_W             = 10;
    localparam int unsigned POR_W             = 5;

    // ------------------------------------------------------------------
    // Bus and register map (index, byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W            = 32;
    localparam int unsigned DATA_W            = 32;
    localparam int unsigned IDX_W             = 16;
    localparam logic [IDX_W-1:0] MISC0_IDX    = 16'hFFF1;
    localparam logic [IDX_W-1:0] EXTIRQ5_IDX  = 16'hFF94;
    localparam logic [IDX_W-1:0] CARDCTL_IDX  = 16'hFFE0;
    localparam logic [IDX_W-1:0] STATUS_IDX   = 16'hFFE1;
    localparam logic              HRESP_OKAY  = 1'b0;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned MISC0_PDCMD_BIT   = 7;
    localparam int unsigned MISC0_PGATE_BIT   = 0;
    localparam int unsigned EXTIRQ5_WAKE_BIT  = 7;
    localparam int unsigned CARDCTL_OFFACK_BIT = 0;
    localparam int unsigned ST_STATE_LSB      = 0;
    localparam int unsigned ST_SUPPLY_LSB     = 3;
    localparam int unsigned ST_SHREQ_BIT      = 5;
    localparam int unsigned ST_BUS_BIT        = 6;
    localparam int unsigned ST_SWON_BIT       = 7;
    localparam logic [7:0]  MISC0_RST         = 8'h00;
    localparam logic [7:0]  EXTIRQ5_RST       = 8'h00;
    localparam logic [7:0]  CARDCTL_RST       = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PWS_OFF        = 3'b000,
        PWS_ON         = 3'b001,
        PWS_CARD_DEACT = 3'b010,
        PWS_PD_DELAY   = 3'b011,
        PWS_STANDBY    = 3'b100,
        PWS_WAKE       = 3'b101
    } pws_state_e;

    typedef enum logic [1:0] {
        PWS_SUP_NONE = 2'b00,
        PWS_SUP_BUS  = 2'b01,
        PWS_SUP_BAT  = 2'b10
    } pws_supply_e;

endpackage
`default_nettype wire

/* File: pws_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module pws_sequencer #(
    parameter int unsigned DEBOUNCE_CYCLES = pws_pkg::DEBOUNCE_CYCLES_DEF
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         onOffSwitchN,
    input  wire logic                         busSupplyPin,
    input  wire logic                         batterySupplyPin,
    input  wire logic                         cardSupplyReq,
    input  wire logic                         cardIdle,
    input  wire logic                         irqUserPins,
    input  wire logic                         irqSmartCard,
    input  wire logic                         irqKeypad,
    input  wire logic                         hsel,
    input  wire logic [pws_pkg::ADDR_W-1:0]   haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [pws_pkg::DATA_W-1:0]   hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [pws_pkg::DATA_W-1:0]        hrdata,
    output logic                              busSwitchOn,
    output logic                              batterySwitchOn,
    output logic                              converterEnable,
    output logic                              converterBypass,
    output logic                              logicSupplyEnable,
    output logic                              digitalResetN,
    output logic                              shutdownRequest,
    output logic                              cardDeactivate,
    output logic                              analogEnable,
    output logic                              clockSubsysEnable,
    output logic                              cpuClockGate,
    output logic                              periphClockGate,
    output logic                              extIrq0
);
    import pws_pkg::*;

    // ------------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------------
    localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYCLES - 1);
    localparam logic [DEB_W-1:0] DEB_MAX  = DEB_W'(DEBOUNCE_CYCLES);
    localparam logic [DLY_W-1:0] PD_LAST  = DLY_W'(PD_DELAY_CYCLES - 1);
    localparam logic [DLY_W-1:0] WK_LAST  = DLY_W'(WAKE_DELAY_CYCLES - 1);
    localparam logic [POR_W-1:0] POR_LOAD = POR_W'(POR_CYCLES);

    // ------------------------------------------------------------------
    // Whole state of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              swSync1;
        logic              swSync2;
        logic              busSync1;
        logic              busSync2;
        logic              batSync1;
        logic              batSync2;
        logic [DEB_W-1:0]  debCount;
        pws_state_e        state;
        pws_supply_e       supplySel;
        logic              switchOn;
        logic              shutdownReq;
        logic [POR_W-1:0]  porCount;
        logic [DLY_W-1:0]  delayCount;
        logic              wakeRouteEnable;
        logic              powerDownCmd;
        logic              periphGateBit;
        logic              offAckBit;
        logic              wakeLatched;
        logic              wrPending;
        logic [IDX_W-1:0]  wrIndex;
        logic              wrMapped;
        logic              rdWait;
        logic [IDX_W-1:0]  rdIndex;
        logic              rdMapped;
        logic [DATA_W-1:0] rdData;
        logic              busOn;
        logic              batOn;
        logic              convOn;
        logic              bypassOn;
        logic              logicOn;
        logic              resetRel;
        logic              cardDeact;
        logic              analogOn;
        logic              clocksOn;
        logic              cpuGate;
        logic              perGate;
        logic              irqOut;
    } pws_regs_s;

    pws_regs_s stateReg;
    pws_regs_s stateNext;

    // ------------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------------
    // Word aligned, inside the index window and on one of the four registers
    function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
        logic [IDX_W-1:0] idx;
        idx = a[IDX_W+1:2];
        addrMapped = (a[ADDR_W-1:IDX_W+2] == '0) && (a[1:0] == 2'b00) &&
                     (idx == MISC0_IDX || idx == EXTIRQ5_IDX ||
                      idx == CARDCTL_IDX || idx == STATUS_IDX);
    endfunction

    function automatic logic [IDX_W-1:0] addrIndex(
        input logic [ADDR_W-1:0] a);
        addrIndex = a[IDX_W+1:2];
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic        busPresent;
    logic        batPresent;
    logic        pressEvent;
    logic        addrTaken;
    logic        wrEvent;
    logic        pdWrite;
    logic        offAckWrite;
    logic        wakeAny;
    logic        enterOn;
    pws_supply_e supplyWant;

    always_comb begin
        stateNext = stateReg;
        pdWrite = 1'b0;
        offAckWrite = 1'b0;
        enterOn = 1'b0;

        // Two-stage synchronisers for the pins
        stateNext.swSync1  = onOffSwitchN;
        stateNext.swSync2  = stateReg.swSync1;
        stateNext.busSync1 = busSupplyPin;
        stateNext.busSync2 = stateReg.busSync1;
        stateNext.batSync1 = batterySupplyPin;
        stateNext.batSync2 = stateReg.batSync1;
        busPresent = stateReg.busSync2;
        batPresent = stateReg.batSync2;

        // Debounce on the free-running clock; one event per hold
        pressEvent = !stateReg.swSync2 && (stateReg.debCount == DEB_LAST);
        if (stateReg.swSync2) begin
            stateNext.debCount = '0;
        end else if (stateReg.debCount != DEB_MAX) begin
            stateNext.debCount = stateReg.debCount + DEB_W'(1);
        end

        // Break-before-make source selection, bus first
        supplyWant = busPresent ? PWS_SUP_BUS :
                     (batPresent ? PWS_SUP_BAT : PWS_SUP_NONE);
        if (stateReg.supplySel != supplyWant) begin
            stateNext.supplySel = (stateReg.supplySel == PWS_SUP_NONE) ?
                                  supplyWant : PWS_SUP_NONE;
        end

        // Register writes land in the data phase
        wrEvent = stateReg.wrPending && stateReg.wrMapped;
        if (wrEvent) begin
            unique case (stateReg.wrIndex)
                MISC0_IDX: begin
                    // Power-down command bit
                    pdWrite = hwdata[MISC0_PDCMD_BIT];
                    stateNext.powerDownCmd = hwdata[MISC0_PDCMD_BIT];
                    stateNext.periphGateBit = hwdata[MISC0_PGATE_BIT];
                end
                EXTIRQ5_IDX: begin
                    stateNext.wakeRouteEnable =
                        hwdata[EXTIRQ5_WAKE_BIT];
                end
                CARDCTL_IDX: begin
                    offAckWrite = hwdata[CARDCTL_OFFACK_BIT];
                    stateNext.offAckBit = hwdata[CARDCTL_OFFACK_BIT];
                end
                default: begin
                end
            endcase
        end

        // Read of the wake routing register clears the enable
        if (stateReg.rdWait && stateReg.rdMapped &&
            stateReg.rdIndex == EXTIRQ5_IDX) begin
            stateNext.wakeRouteEnable = 1'b0;
        end

        // Wake sources 0, 4 and 5 ORed and held until taken
        wakeAny = irqUserPins || irqSmartCard || irqKeypad;
        if (stateReg.state == PWS_STANDBY && stateReg.wakeRouteEnable &&
            wakeAny) begin
            stateNext.wakeLatched = 1'b1;
        end

        // Shutdown request: set on ON press, bus overrides switch
        if (stateReg.state != PWS_OFF && pressEvent && !busPresent) begin
            stateNext.shutdownReq = 1'b1;
        end

        stateNext.irqOut = 1'b0;
        if (stateReg.porCount != '0) begin
            stateNext.porCount = stateReg.porCount - POR_W'(1);
        end

        // Power state machine
        unique case (stateReg.state)
            PWS_OFF: begin
                // Bus forces ON; otherwise only the switch acts,
                // a switch tied low turns on once powered
                if (busPresent || pressEvent) begin
                    enterOn = 1'b1;
                    stateNext.switchOn = pressEvent && !busPresent;
                end
            end
            PWS_ON: begin
                if (offAckWrite && !busPresent) begin
                    // Acknowledge, requested or not
                    stateNext.state = PWS_CARD_DEACT;
                end else if (pdWrite) begin
                    stateNext.state = PWS_PD_DELAY;
                    stateNext.delayCount = '0;
                end
                if (offAckWrite && busPresent) begin
                    stateNext.offAckBit = 1'b0;  // Ignored while bus powers
                end
            end
            PWS_CARD_DEACT: begin
                // Card shut down before the supplies go
                if (busPresent) begin
                    stateNext.state = PWS_ON;
                    stateNext.offAckBit = 1'b0;
                end else if (cardIdle) begin
                    stateNext.state = PWS_OFF;
                    stateNext.switchOn = 1'b0;
                end
            end
            PWS_PD_DELAY: begin
                // Grace time for the core to stop itself
                stateNext.delayCount = stateReg.delayCount + DLY_W'(1);
                if (stateReg.delayCount == PD_LAST) begin
                    if (busPresent || stateReg.switchOn) begin
                        stateNext.state = PWS_STANDBY;
                        stateNext.wakeLatched = 1'b0;
                    end else begin
                        stateNext.state = PWS_OFF;
                        stateNext.switchOn = 1'b0;
                    end
                end
            end
            PWS_STANDBY: begin
                // Any routed wake restores power and clocks
                if (stateReg.wakeLatched) begin
                    stateNext.state = PWS_WAKE;
                    stateNext.delayCount = '0;
                end
            end
            PWS_WAKE: begin
                // Settling count before the interrupt shows
                stateNext.delayCount = stateReg.delayCount + DLY_W'(1);
                if (stateReg.delayCount == WK_LAST) begin
                    stateNext.state = PWS_ON;
                    stateNext.irqOut = 1'b1;
                    stateNext.powerDownCmd = 1'b0;
                    stateNext.wakeLatched = 1'b0;
                end
            end
            default: begin
                stateNext.state = PWS_OFF;
            end
        endcase

        // Turn-on: logic supply up under a power-on reset, which alone
        // clears the request; it also loads the software register resets
        if (enterOn) begin
            stateNext.state = PWS_ON;
            stateNext.porCount = POR_LOAD;
            stateNext.shutdownReq = 1'b0;
            stateNext.powerDownCmd = MISC0_RST[MISC0_PDCMD_BIT];
            stateNext.periphGateBit = MISC0_RST[MISC0_PGATE_BIT];
            stateNext.wakeRouteEnable = EXTIRQ5_RST[EXTIRQ5_WAKE_BIT];
            stateNext.offAckBit = CARDCTL_RST[CARDCTL_OFFACK_BIT];
            stateNext.wakeLatched = 1'b0;
        end

        // Bus slave: writes zero-wait, reads one wait state so the data
        // reflects any write finished just before
        addrTaken = hsel && htrans[1] && hready;
        stateNext.wrPending = addrTaken && hwrite;
        stateNext.wrIndex = addrIndex(haddr);
        stateNext.wrMapped = addrMapped(haddr);
        stateNext.rdWait = addrTaken && !hwrite;
        if (addrTaken && !hwrite) begin
            stateNext.rdIndex = addrIndex(haddr);
            stateNext.rdMapped = addrMapped(haddr);
        end
        if (stateReg.rdWait) begin
            stateNext.rdData = '0;
            if (stateReg.rdMapped) begin
                unique case (stateReg.rdIndex)
                    MISC0_IDX: begin
                        stateNext.rdData[MISC0_PDCMD_BIT] =
                            stateReg.powerDownCmd;
                        stateNext.rdData[MISC0_PGATE_BIT] =
                            stateReg.periphGateBit;
                    end
                    EXTIRQ5_IDX: begin
                        stateNext.rdData[EXTIRQ5_WAKE_BIT] =
                            stateReg.wakeRouteEnable;
                    end
                    CARDCTL_IDX: begin
                        stateNext.rdData[CARDCTL_OFFACK_BIT] =
                            stateReg.offAckBit;
                    end
                    STATUS_IDX: begin
                        stateNext.rdData[ST_STATE_LSB+:3] = stateReg.state;
                        stateNext.rdData[ST_SUPPLY_LSB+:2] =
                            stateReg.supplySel;
                        stateNext.rdData[ST_SHREQ_BIT] = stateReg.shutdownReq;
                        stateNext.rdData[ST_BUS_BIT] = busPresent;
                        stateNext.rdData[ST_SWON_BIT] = stateReg.switchOn;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Registered controls decoded from the next state
        stateNext.busOn = (stateNext.supplySel == PWS_SUP_BUS);
        stateNext.batOn = (stateNext.supplySel == PWS_SUP_BAT);
        stateNext.convOn = (stateNext.state != PWS_OFF);
        stateNext.logicOn = (stateNext.state != PWS_OFF);
        stateNext.bypassOn = stateNext.convOn && stateNext.busOn &&
                             !cardSupplyReq;
        stateNext.resetRel = stateNext.logicOn &&
                             (stateNext.porCount == '0);
        stateNext.cardDeact = (stateNext.state == PWS_CARD_DEACT);
        // Analog, clocks and core all halt in standby
        stateNext.analogOn = stateNext.logicOn &&
                             (stateNext.state != PWS_STANDBY);
        stateNext.clocksOn = stateNext.analogOn;
        stateNext.cpuGate = (stateNext.state == PWS_STANDBY) ||
                            (stateNext.state == PWS_WAKE);
        // The command overrides the individual gate bit
        stateNext.perGate = stateNext.powerDownCmd ? stateNext.cpuGate :
                            stateNext.periphGateBit;
    end

    // ------------------------------------------------------------------
    // State register; reset stands for supply application
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= '{
                swSync1: 1'b1, swSync2: 1'b1,
                busSync1: 1'b0, busSync2: 1'b0,
                batSync1: 1'b0, batSync2: 1'b0,
                state: PWS_OFF, supplySel: PWS_SUP_NONE,
                default: '0
            };
        end else begin
            stateReg <= stateNext;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Wait state only while a read is being fetched
    assign hreadyout         = !stateReg.rdWait;
    assign hresp             = HRESP_OKAY;
    assign hrdata            = stateReg.rdData;
    assign busSwitchOn       = stateReg.busOn;
    assign batterySwitchOn   = stateReg.batOn;
    assign converterEnable   = stateReg.convOn;
    assign converterBypass   = stateReg.bypassOn;
    assign logicSupplyEnable = stateReg.logicOn;
    assign digitalResetN     = stateReg.resetRel;
    assign shutdownRequest   = stateReg.shutdownReq;
    assign cardDeactivate    = stateReg.cardDeact;
    assign analogEnable      = stateReg.analogOn;
    assign clockSubsysEnable = stateReg.clocksOn;
    assign cpuClockGate      = stateReg.cpuGate;
    assign periphClockGate   = stateReg.perGate;
    assign extIrq0           = stateReg.irqOut;

    // hsize is always a word here; nothing depends on it
    logic hsizeUnused;
    assign hsizeUnused = ^hsize;

endmodule
`default_nettype wire

/* File: pws_sequencer_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// Supply, power-rail and wake checks on the sequencer's ports
module pws_sequencer_asserts (
    input wire logic clk, rst_n, cardSupplyReq, busSwitchOn, batterySwitchOn,
    input wire logic converterEnable, converterBypass, logicSupplyEnable,
    input wire logic digitalResetN, shutdownRequest, analogEnable,
    input wire logic clockSubsysEnable, cpuClockGate, extIrq0
);
    logic [11:0] wakeRun;
    // Cycles with clocks back up and the core still gated; a wake
    // interrupt may only show once this has reached the full count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeRun <= 12'h000;
        end else if (cpuClockGate && clockSubsysEnable) begin
            wakeRun <= wakeRun + 12'h001;
        end else begin
            wakeRun <= 12'h000;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_one_supply: assert property (
        !(busSwitchOn && batterySwitchOn)) else $error("both sources on");
    a_por_hold: assert property (
        $rose(logicSupplyEnable) |-> !digitalResetN [*8])
        else $error("reset released early");
    a_off_dark: assert property (
        !logicSupplyEnable |-> !digitalResetN && !analogEnable
            && !clockSubsysEnable) else $error("logic alive while off");
    a_bypass_bus: assert property (
        converterBypass |-> busSwitchOn && !$past(cardSupplyReq))
        else $error("bypass without bus");
    a_rail_pair: assert property (
        converterEnable == logicSupplyEnable) else $error("rails split");
    a_irq_pulse: assert property (
        extIrq0 |=> !extIrq0) else $error("wake irq too long");
    a_irq_delay: assert property (
        extIrq0 |-> wakeRun >= 12'h200) else $error("wake irq early");
    a_req_sticky: assert property (
        $fell(shutdownRequest) |-> !$past(digitalResetN))
        else $error("request dropped");
endmodule
`default_nettype wire

/* File: pws_partner.sv */
`timescale 1ns/100ps
`default_nettype none
// Switch, supplies and card interface outside the sequencer
module pws_partner (
    input  wire logic clk, press, busOn, cardDeactivate,
    output logic      onOffSwitchN, busSupplyPin, batterySupplyPin, cardIdle
);
    logic [3:0] dly = 4'h0;
    initial {onOffSwitchN, busSupplyPin, batterySupplyPin, cardIdle} = 4'hE;
    // Card winds down over 16 cycles, so the sequencer must wait for it
    always @(posedge clk) begin
        onOffSwitchN <= !press;
        busSupplyPin <= busOn;
        batterySupplyPin <= 1'b1;
        dly <= cardDeactivate ? dly + 4'h1 : 4'h0;
        cardIdle <= &dly;
    end
endmodule
`default_nettype wire

/* File: pws_sequencer_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module pws_sequencer_bench;
    import pws_pkg::*;
    logic clk = 0, rst_n = 0, press = 0, busOn = 1, cardSupplyReq = 0;
    logic hsel = 0, hwrite = 0;
    logic [2:0] irqs = 0, hsize = 3'b010;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [7:0] rd;
    wire logic hreadyout, hresp, busSwitchOn, batterySwitchOn, extIrq0,
        converterEnable, converterBypass, logicSupplyEnable, digitalResetN,
        shutdownRequest, cardDeactivate, analogEnable, clockSubsysEnable,
        cpuClockGate, periphClockGate, onOffSwitchN, busSupplyPin,
        batterySupplyPin, cardIdle;
    wire logic [31:0] hrdata;
    wire logic hready = hreadyout;
    wire logic irqUserPins = irqs[0], irqSmartCard = irqs[1];
    wire logic irqKeypad = irqs[2];
    int errors = 0, samplesChecked = 0, n;
    always #4 clk = ~clk;
    pws_partner i_pws_partner (.*);
    pws_sequencer #(.DEBOUNCE_CYCLES(8)) i_pws_sequencer (.*);
    task automatic chk(input logic [7:0] got, exp);
        samplesChecked++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single AHB transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [15:0] i,
                       input logic [7:0] d);
        hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {14'h0, i, 2'b00};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 0; hwdata <= {24'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata[7:0];
    endtask
    task automatic st(input logic [7:0] e);
        ahb(0, STATUS_IDX, 0);
        chk(rd & 8'h1F, e);
        chk(hresp, 0);
    endtask
    task automatic hold(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic tap;
        press <= 1; hold(20); press <= 0; hold(10);
    endtask
    task automatic t_bus;
        for (n = 0; n < 99 && digitalResetN !== 1'b1; n++) hold(1);
        st({3'h0, PWS_SUP_BUS, PWS_ON});
        chk(converterBypass, 1);
        chk({busSwitchOn, batterySwitchOn}, 2);
        cardSupplyReq <= 1; hold(4); chk(converterBypass, 0);
        tap; chk(shutdownRequest, 0);
        ahb(1, CARDCTL_IDX, 1); hold(8);
        st({3'h0, PWS_SUP_BUS, PWS_ON});
    endtask
    task automatic t_batt;
        busOn <= 0; hold(8);
        st({3'h0, PWS_SUP_BAT, PWS_ON});
        chk({busSwitchOn, batterySwitchOn}, 1);
        ahb(1, MISC0_IDX, 8'h80); hold(40);
        chk(logicSupplyEnable, 0);
    endtask
    task automatic t_on;
        tap;
        for (n = 0; n < 99 && digitalResetN !== 1'b1; n++) hold(1);
        chk(shutdownRequest, 0);
        st({3'h0, PWS_SUP_BAT, PWS_ON});
    endtask
    task automatic t_req;
        tap; hold(20); chk(shutdownRequest, 1);
        ahb(1, CARDCTL_IDX, 1); hold(3);
        chk(cardDeactivate, 1);
        hold(30); chk(logicSupplyEnable, 0);
    endtask
    task automatic t_wake;
        for (int i = 0; i < 3; i++) begin
            ahb(1, EXTIRQ5_IDX, 8'h80);
            ahb(0, EXTIRQ5_IDX, 0); chk(rd[7], 1);
            ahb(0, EXTIRQ5_IDX, 0); chk(rd[7], 0);
            ahb(1, EXTIRQ5_IDX, 8'h80);
            ahb(1, MISC0_IDX, 8'h80);
            hold(31); // Bus stays quiet while the core halts
            chk(analogEnable, 1);
            hold(2); chk({cpuClockGate, analogEnable}, 2);
            chk(periphClockGate, 1);
            st({3'h0, PWS_SUP_BAT, PWS_STANDBY});
            irqs[i] <= 1; hold(2); irqs[i] <= 0;
            for (n = 0; n < 700 && extIrq0 !== 1'b1; n++) hold(1);
            chk(n >= 512 && n < 700, 1);
            chk(clockSubsysEnable, 1);
        end
    endtask
    // Switch held low through a supply-up reset: turns on by itself,
    // and the one long hold must not also raise a shutdown request
    task automatic t_tied;
        press <= 1; rst_n <= 0; hold(2); rst_n <= 1;
        for (n = 0; n < 99 && digitalResetN !== 1'b1; n++) hold(1);
        st({3'h0, PWS_SUP_BAT, PWS_ON});
        hold(20); chk(shutdownRequest, 0);
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", errors, samplesChecked);
        if (errors == 0 && samplesChecked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence, and a watchdog well beyond its length
    initial begin
        hold(16); rst_n <= 1;
        t_bus; t_batt; t_on; t_req; t_on; t_wake; t_tied;
        finish_test;
    end
    initial begin
        hold(20000); errors++; finish_test;
    end
endmodule
bind pws_sequencer pws_sequencer_asserts i_pws_sequencer_asserts (.*);
`default_nettype wire
